// ### common/pod_map.vh
// Purpose: Register map, reset values and timing counts for the pin override/debounce block
// Assumes: 25 MHz aclk; register index times four is the AXI byte address
// Notes: Definitions only
`ifndef POD_MAP_VH
`define POD_MAP_VH

// Register indexes
`define POD_IDX_UPD_COMMIT 8'h5b
`define POD_IDX_OVR_SEL0 8'h60
`define POD_IDX_OVR_SEL1 8'h62
`define POD_IDX_OVR_SEL2 8'h64
`define POD_IDX_OVR_SEL3 8'h66
`define POD_IDX_OVR_OUT 8'h68
`define POD_IDX_OVR_DIR 8'h6a
`define POD_IDX_DB_COARSE 8'h6c
`define POD_IDX_DB_MEDIUM 8'h6d
`define POD_IDX_DB_FINE 8'h6e
`define POD_IDX_DB_STS 8'h6f
`define POD_IDX_DB_SEL 8'h70
`define POD_IDX_MON_VAL 8'h54
`define POD_IDX_OVR_EN 8'h55
`define POD_IDX_OVR_ACT 8'h56
`define POD_IDX_MON_PIN 8'h90
`define POD_IDX_NRM_OUT 8'h91
`define POD_IDX_NRM_DIR 8'h92
`define POD_IDX_INT_STS 8'h93
`define POD_IDX_INT_MSK 8'h94
`define POD_IDX_PIN_IN 8'h95

// Reset values
`define POD_RST_16 16'h0000
`define POD_RST_DB_CNT 8'h0a
`define POD_RST_DB_SEL 32'h00000000
`define POD_RST_4 4'h0

// Fields
`define POD_DB_STS_PEND_BIT 0
`define POD_DB_SEL_OFF 2'h0
`define POD_DB_SEL_FINE 2'h1
`define POD_DB_SEL_MEDIUM 2'h2
`define POD_DB_SEL_COARSE 2'h3

// AXI responses
`define POD_RESP_OKAY 2'h0
`define POD_RESP_SLVERR 2'h2

// Timing: period and time bases in their own units
`define POD_CLK_NS 40
`define POD_FINE_NS 1000
`define POD_MEDIUM_US 1000
`define POD_COARSE_MS 10
// Last count of each divider, one less than its ratio
`define POD_FINE_LAST 5'h18
`define POD_MEDIUM_LAST 10'h3e7
`define POD_COARSE_LAST 4'h9

`endif

// ### logic/pod_top.v
// Purpose: Sixteen general pins with four override functions and per-pin debouncers
// Assumes: Single 25 MHz clock, synchronous active-low reset, pin inputs synchronous
// Notes: AXI4-Lite register slave, one level interrupt on override activation
// How it works
// - Each of four override functions owns a 16-bit mask of the pins whose output it controls.
// - One pin may sit in several override masks at once without any error.
// - A selected pin of an active override drives its bit of the override output value.
// - A selected pin of an active override takes its direction from the override direction field.
// - The coarse count, reset 0x0a, counts 10 ms units for pins using the 10 ms base.
// - The medium count, reset 0x0a, counts 1 ms units for pins using the 1 ms base.
// - The fine count, reset 0x0a, counts 1 us units for pins using the 1 us base.
// - A debounced pin ignores any input change shorter than its debounce count less one unit.
// - The real debounce length is the count or one unit less, by the tick phase.
// - Status bit 0 reads one while any pin debounce is pending, upper bits zero.
// - Each pin has a 2-bit debounce select at bits 2n+1:2n: off, 1 us, 1 ms, 10 ms.
// - An enabled override goes active when its monitored pin equals its value, and stays until disabled.
// - Each override works only while its own enable bit is set.
`timescale 1ns/1ps
`include "pod_map.vh"
module pod_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [9:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [9:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // General pins
  input wire [15:0] general_pin_in,
  output reg [15:0] general_pin_out,
  output reg [15:0] general_pin_oe_n,
  // Interrupt
  output reg irq
);

  // Register storage
  reg [15:0] upd_commit_ff;
  reg [15:0] ovr_sel_ff [0:3];
  reg [15:0] ovr_out_ff;
  reg [15:0] ovr_dir_ff;
  reg [7:0] db_coarse_ff;
  reg [7:0] db_medium_ff;
  reg [7:0] db_fine_ff;
  reg [31:0] db_sel_ff;
  reg [3:0] mon_val_ff;
  reg [3:0] ovr_en_ff;
  reg [3:0] ovr_act_ff;
  reg [15:0] mon_pin_ff;
  reg [15:0] nrm_out_ff;
  reg [15:0] nrm_dir_ff;
  reg [3:0] int_sts_ff;
  reg [3:0] int_msk_ff;

  // Held write channels
  reg aw_held_ff;
  reg w_held_ff;
  reg [7:0] aw_idx_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;

  wire [15:0] db_pin;
  wire [15:0] db_pend;
  wire [3:0] ovr_act_nxt;

  // Time base dividers: one-cycle enables
  reg [4:0] fine_div_ff;
  reg [9:0] med_div_ff;
  reg [3:0] crs_div_ff;
  reg tick_us_ff;
  reg tick_ms_ff;
  reg tick_10ms_ff;
  wire fine_wrap = (fine_div_ff == `POD_FINE_LAST);
  wire med_wrap = fine_wrap && (med_div_ff == `POD_MEDIUM_LAST);
  wire crs_wrap = med_wrap && (crs_div_ff == `POD_COARSE_LAST);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fine_div_ff <= 5'h00;
      med_div_ff <= 10'h000;
      crs_div_ff <= 4'h0;
      tick_us_ff <= 1'b0;
      tick_ms_ff <= 1'b0;
      tick_10ms_ff <= 1'b0;
    end
    else
    begin
      fine_div_ff <= fine_wrap ? 5'h00 : fine_div_ff + 5'h01;
      if (fine_wrap)
        med_div_ff <= med_wrap ? 10'h000 : med_div_ff + 10'h001;
      if (med_wrap)
        crs_div_ff <= crs_wrap ? 4'h0 : crs_div_ff + 4'h1;
      tick_us_ff <= fine_wrap;
      tick_ms_ff <= med_wrap;
      tick_10ms_ff <= crs_wrap;
    end
  end

  // Per-pin debouncers
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_pin
      wire [1:0] sel = db_sel_ff[2*gi+1:2*gi];
      reg state_ff;
      reg [7:0] cnt_ff;
      wire [7:0] lim = (sel == `POD_DB_SEL_FINE) ? db_fine_ff
        : (sel == `POD_DB_SEL_MEDIUM) ? db_medium_ff : db_coarse_ff;
      wire tk = (sel == `POD_DB_SEL_FINE) ? tick_us_ff
        : (sel == `POD_DB_SEL_MEDIUM) ? tick_ms_ff : tick_10ms_ff;
      // Counter starts at an arbitrary tick phase, so length is lim-1 to lim units
      always @(posedge aclk)
      begin
        if (!aresetn)
        begin
          state_ff <= 1'b0;
          cnt_ff <= 8'h00;
        end
        else if (sel == `POD_DB_SEL_OFF)
        begin
          state_ff <= general_pin_in[gi];
          cnt_ff <= 8'h00;
        end
        else if (general_pin_in[gi] == state_ff)
          cnt_ff <= 8'h00;
        else if (tk)
        begin
          if ({1'b0, cnt_ff} + 9'h001 >= {1'b0, lim})
          begin
            state_ff <= general_pin_in[gi];
            cnt_ff <= 8'h00;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        end
      end
      assign db_pin[gi] = state_ff;
      assign db_pend[gi] = (sel != `POD_DB_SEL_OFF) && (general_pin_in[gi] != state_ff);
    end
  endgenerate

  // Override triggers
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_ovr
      wire match = (db_pin[mon_pin_ff[4*gi+3:4*gi]] == mon_val_ff[gi]);
      assign ovr_act_nxt[gi] = ovr_en_ff[gi] && (ovr_act_ff[gi] || match);
    end
  endgenerate

  // Pin drive, later overrides need no priority since all share one value
  wire [15:0] taken = (ovr_sel_ff[0] & {16{ovr_act_ff[0]}}) | (ovr_sel_ff[1] & {16{ovr_act_ff[1]}})
    | (ovr_sel_ff[2] & {16{ovr_act_ff[2]}}) | (ovr_sel_ff[3] & {16{ovr_act_ff[3]}});

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      general_pin_out <= `POD_RST_16;
      general_pin_oe_n <= 16'hffff;
      ovr_act_ff <= `POD_RST_4;
      irq <= 1'b0;
    end
    else
    begin
      general_pin_out <= (taken & ovr_out_ff) | (~taken & nrm_out_ff);
      general_pin_oe_n <= ~((taken & ovr_dir_ff) | (~taken & nrm_dir_ff));
      ovr_act_ff <= ovr_act_nxt;
      irq <= |(int_sts_ff & int_msk_ff);
    end
  end

  // Write path
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_wr = aw_held_ff && w_held_ff && !s_axi_bvalid;
  wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  wire [15:0] wd16 = w_data_ff[15:0];
  wire [15:0] wm16 = wmask[15:0];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [31:0] msk;
    begin
      merge = (old & ~msk) | (dat & msk);
    end
  endfunction

  reg wr_ok;
  always @*
  begin
    case (aw_idx_ff)
      `POD_IDX_UPD_COMMIT, `POD_IDX_OVR_SEL0, `POD_IDX_OVR_SEL1, `POD_IDX_OVR_SEL2,
      `POD_IDX_OVR_SEL3, `POD_IDX_OVR_OUT, `POD_IDX_OVR_DIR, `POD_IDX_DB_COARSE,
      `POD_IDX_DB_MEDIUM, `POD_IDX_DB_FINE, `POD_IDX_DB_STS, `POD_IDX_DB_SEL,
      `POD_IDX_MON_VAL, `POD_IDX_OVR_EN, `POD_IDX_OVR_ACT, `POD_IDX_MON_PIN,
      `POD_IDX_NRM_OUT, `POD_IDX_NRM_DIR, `POD_IDX_INT_STS, `POD_IDX_INT_MSK,
      `POD_IDX_PIN_IN: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  wire [3:0] int_clr = (do_wr && aw_idx_ff == `POD_IDX_INT_STS) ? (wd16[3:0] & wm16[3:0]) : 4'h0;
  wire [3:0] int_set = ovr_act_nxt & ~ovr_act_ff;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `POD_RESP_OKAY;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= 8'h00;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      upd_commit_ff <= `POD_RST_16;
      ovr_sel_ff[0] <= `POD_RST_16;
      ovr_sel_ff[1] <= `POD_RST_16;
      ovr_sel_ff[2] <= `POD_RST_16;
      ovr_sel_ff[3] <= `POD_RST_16;
      ovr_out_ff <= `POD_RST_16;
      ovr_dir_ff <= `POD_RST_16;
      db_coarse_ff <= `POD_RST_DB_CNT;
      db_medium_ff <= `POD_RST_DB_CNT;
      db_fine_ff <= `POD_RST_DB_CNT;
      db_sel_ff <= `POD_RST_DB_SEL;
      mon_val_ff <= `POD_RST_4;
      ovr_en_ff <= `POD_RST_4;
      mon_pin_ff <= `POD_RST_16;
      nrm_out_ff <= `POD_RST_16;
      nrm_dir_ff <= `POD_RST_16;
      int_sts_ff <= `POD_RST_4;
      int_msk_ff <= `POD_RST_4;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= s_axi_awaddr[9:2];
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `POD_RESP_OKAY : `POD_RESP_SLVERR;
        case (aw_idx_ff)
          `POD_IDX_UPD_COMMIT: upd_commit_ff <= (upd_commit_ff & ~wm16) | (wd16 & wm16);
          `POD_IDX_OVR_SEL0: ovr_sel_ff[0] <= (ovr_sel_ff[0] & ~wm16) | (wd16 & wm16);
          `POD_IDX_OVR_SEL1: ovr_sel_ff[1] <= (ovr_sel_ff[1] & ~wm16) | (wd16 & wm16);
          `POD_IDX_OVR_SEL2: ovr_sel_ff[2] <= (ovr_sel_ff[2] & ~wm16) | (wd16 & wm16);
          `POD_IDX_OVR_SEL3: ovr_sel_ff[3] <= (ovr_sel_ff[3] & ~wm16) | (wd16 & wm16);
          `POD_IDX_OVR_OUT: ovr_out_ff <= (ovr_out_ff & ~wm16) | (wd16 & wm16);
          `POD_IDX_OVR_DIR: ovr_dir_ff <= (ovr_dir_ff & ~wm16) | (wd16 & wm16);
          `POD_IDX_DB_COARSE: db_coarse_ff <= w_strb_ff[0] ? w_data_ff[7:0] : db_coarse_ff;
          `POD_IDX_DB_MEDIUM: db_medium_ff <= w_strb_ff[0] ? w_data_ff[7:0] : db_medium_ff;
          `POD_IDX_DB_FINE: db_fine_ff <= w_strb_ff[0] ? w_data_ff[7:0] : db_fine_ff;
          `POD_IDX_DB_SEL: db_sel_ff <= merge(db_sel_ff, w_data_ff, wmask);
          `POD_IDX_MON_VAL: mon_val_ff <= w_strb_ff[0] ? w_data_ff[3:0] : mon_val_ff;
          `POD_IDX_OVR_EN: ovr_en_ff <= w_strb_ff[0] ? w_data_ff[3:0] : ovr_en_ff;
          `POD_IDX_MON_PIN: mon_pin_ff <= (mon_pin_ff & ~wm16) | (wd16 & wm16);
          `POD_IDX_NRM_OUT: nrm_out_ff <= (nrm_out_ff & ~wm16) | (wd16 & wm16);
          `POD_IDX_NRM_DIR: nrm_dir_ff <= (nrm_dir_ff & ~wm16) | (wd16 & wm16);
          `POD_IDX_INT_MSK: int_msk_ff <= w_strb_ff[0] ? w_data_ff[3:0] : int_msk_ff;
          default: upd_commit_ff <= upd_commit_ff;
        endcase
      end
      // New activation beats a same-cycle clear
      int_sts_ff <= (int_sts_ff & ~int_clr) | int_set;
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read path
  wire [7:0] ar_idx = s_axi_araddr[9:2];
  reg [31:0] rd_val;
  reg rd_ok;
  always @*
  begin
    rd_ok = 1'b1;
    case (ar_idx)
      `POD_IDX_UPD_COMMIT: rd_val = {16'h0000, upd_commit_ff};
      `POD_IDX_OVR_SEL0: rd_val = {16'h0000, ovr_sel_ff[0]};
      `POD_IDX_OVR_SEL1: rd_val = {16'h0000, ovr_sel_ff[1]};
      `POD_IDX_OVR_SEL2: rd_val = {16'h0000, ovr_sel_ff[2]};
      `POD_IDX_OVR_SEL3: rd_val = {16'h0000, ovr_sel_ff[3]};
      `POD_IDX_OVR_OUT: rd_val = {16'h0000, ovr_out_ff};
      `POD_IDX_OVR_DIR: rd_val = {16'h0000, ovr_dir_ff};
      `POD_IDX_DB_COARSE: rd_val = {24'h000000, db_coarse_ff};
      `POD_IDX_DB_MEDIUM: rd_val = {24'h000000, db_medium_ff};
      `POD_IDX_DB_FINE: rd_val = {24'h000000, db_fine_ff};
      `POD_IDX_DB_STS: rd_val = {31'h00000000, |db_pend};
      `POD_IDX_DB_SEL: rd_val = db_sel_ff;
      `POD_IDX_MON_VAL: rd_val = {28'h0000000, mon_val_ff};
      `POD_IDX_OVR_EN: rd_val = {28'h0000000, ovr_en_ff};
      `POD_IDX_OVR_ACT: rd_val = {28'h0000000, ovr_act_ff};
      `POD_IDX_MON_PIN: rd_val = {16'h0000, mon_pin_ff};
      `POD_IDX_NRM_OUT: rd_val = {16'h0000, nrm_out_ff};
      `POD_IDX_NRM_DIR: rd_val = {16'h0000, nrm_dir_ff};
      `POD_IDX_INT_STS: rd_val = {28'h0000000, int_sts_ff};
      `POD_IDX_INT_MSK: rd_val = {28'h0000000, int_msk_ff};
      `POD_IDX_PIN_IN: rd_val = {16'h0000, db_pin};
      default:
      begin
        rd_val = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `POD_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `POD_RESP_OKAY : `POD_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // pod_top

// ### tb/pod_pin_model.sv
// Purpose: Outside world on the sixteen general pins
// Assumes: A pin the block drives reads back its own level
// Notes: Undriven pins follow the bench's external value
`timescale 1ns/1ps
module pod_pin_model (
  // Block side
  input wire [15:0] pin_out,
  input wire [15:0] pin_oe_n,
  // Outside world
  input wire [15:0] ext_val,
  output wire [15:0] pin_in
);
  // Block's driver wins, else the outside level
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
endmodule // pod_pin_model

// ### tb/pod_top_assertions.sv
// Purpose: Port checks for the pin override block
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to pod_top
`timescale 1ns/1ps
`include "pod_map.vh"
module pod_top_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Pins
  input wire [15:0] general_pin_out,
  input wire [15:0] general_pin_oe_n,
  input wire irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire aw_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  chk_wr_answer: assert property (aw_take |=> ##1 s_axi_bvalid) else $error("no bvalid");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  chk_rd_answer: assert property (ar_take |=> s_axi_rvalid) else $error("no rvalid");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_bad_write: assert property (aw_take && s_axi_awaddr[9:2] == 8'h80 |=>
    ##1 s_axi_bresp == `POD_RESP_SLVERR) else $error("unmapped write okay");
  chk_bad_read: assert property (ar_take && s_axi_araddr[9:2] == 8'h80 |=>
    s_axi_rresp == `POD_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read okay");
  chk_sts_upper: assert property (ar_take && s_axi_araddr[9:2] == `POD_IDX_DB_STS |=>
    s_axi_rdata[31:1] == 31'h0) else $error("status upper bits set");
  chk_cnt_width: assert property (ar_take && s_axi_araddr[9:2] inside {8'h6c, 8'h6d, 8'h6e} |=>
    s_axi_rdata[31:8] == 24'h0) else $error("count wider than 8 bits");
  chk_reset_pins: assert property ($rose(aresetn) |-> general_pin_oe_n == 16'hffff &&
    general_pin_out == 16'h0 && !irq) else $error("pins not idle after reset");
  cover property (aw_take);
  cover property (ar_take);
  cover property ($rose(irq));
endmodule // pod_top_chk
bind pod_top pod_top_chk chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .general_pin_out, .general_pin_oe_n, .irq);

// ### tb/pod_top_tb.sv
// Purpose: Self-checking bench for the pin override block
// Assumes: 25 MHz clock, bench drives the register bus
// Notes: Slow debounce bases are only checked by register access
`timescale 1ns/1ps
`include "pod_map.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module pod_top_tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
  logic [9:0] awaddr = 10'h0, araddr = 10'h0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [15:0] pin_in, pin_out, oe_n, ext_val = 16'h0;
  int n_mismatch = 0, tests_run = 0;
  time t0;
  always #20 aclk = ~aclk;
  pod_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .general_pin_in(pin_in), .general_pin_out(pin_out),
    .general_pin_oe_n(oe_n), .irq(irq));
  pod_pin_model pins (.pin_out(pin_out), .pin_oe_n(oe_n), .ext_val(ext_val), .pin_in(pin_in));
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tmo(inout int n);
    n++;
    if (n > 400)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t wait ran out", $time);
      finish_test();
    end
  endtask
  task automatic wr(input [7:0] i, input [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      tmo(n);
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] i);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      tmo(n);
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Bounded poll until the masked register reads as expected
  task automatic pol(input [7:0] i, input [31:0] m, input [31:0] e);
    int n;
    n = 0;
    do
    begin
      rd(i);
      tmo(n);
    end
    while ((d & m) !== e);
  endtask
  task automatic t_regs;
    logic [7:0] ix [11];
    logic [31:0] rv [11];
    logic [31:0] mk [11];
    ix = '{8'h5b, 8'h60, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6a, 8'h6c, 8'h6d, 8'h6e, 8'h70};
    rv = '{0, 0, 0, 0, 0, 0, 0, 32'h0a, 32'h0a, 32'h0a, 0};
    mk = '{32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hffff,
      32'hff, 32'hff, 32'hff, 32'hffffffff};
    `CHK(oe_n, 16'hffff)
    for (int k = 0; k < 11; k++)
    begin
      rd(ix[k]);
      `CHK(d, rv[k])
      wr(ix[k], 32'hffffffff);
      rd(ix[k]);
      `CHK(d, mk[k])
      wr(ix[k], rv[k]);
    end
    wr(8'h70, 32'he4e4e4e4);
    rd(8'h70);
    `CHK(d, 32'he4e4e4e4)
    wr(8'h70, 32'h0);
    wr(8'h6f, 32'hff);
    rd(8'h6f);
    `CHK(d, 32'h0)
    wr(8'h80, 32'h1);
    `CHK(r, `POD_RESP_SLVERR)
    rd(8'h80);
    `CHK(r, `POD_RESP_SLVERR)
    $display("test regs done");
  endtask
  task automatic t_ovr;
    wr(8'h91, 32'ha5c3);
    wr(8'h92, 32'h00ff);
    ext_val <= 16'h0100;
    wr(8'h60, 32'h000f);
    wr(8'h62, 32'h0003);
    `CHK(r, `POD_RESP_OKAY)
    wr(8'h68, 32'h0005);
    wr(8'h6a, 32'h000a);
    wr(8'h90, 32'h8);
    wr(8'h54, 32'h1);
    wr(8'h94, 32'h1);
    `CHK(oe_n, 16'hff00)
    `CHK(pin_out[7:0], 8'hc3)
    rd(8'h56);
    `CHK(d[3:0], 4'h0)
    `CHK(irq, 1'b0)
    wr(8'h55, 32'h1);
    pol(8'h56, 32'hf, 32'h1);
    `CHK(d[3:0], 4'h1)
    `CHK(pin_out[7:0], 8'hc5)
    `CHK(oe_n[7:0], 8'h05)
    `CHK(irq, 1'b1)
    ext_val <= 16'h0000;
    repeat (5) @(posedge aclk);
    rd(8'h56);
    `CHK(d[3:0], 4'h1)
    wr(8'h94, 32'h0);
    rd(8'h56);
    `CHK(irq, 1'b0)
    wr(8'h94, 32'h1);
    wr(8'h93, 32'h1);
    rd(8'h93);
    `CHK({d[3:0], irq}, 5'h0)
    wr(8'h55, 32'h0);
    pol(8'h56, 32'hf, 32'h0);
    `CHK({pin_out[3:0], oe_n[3:0]}, 8'h30)
    $display("test override done");
  endtask
  task automatic t_deb;
    wr(8'h6e, 32'h4);
    wr(8'h70, 32'h00040000);
    // A glitch of under three fine units must be swallowed
    ext_val <= 16'h0200;
    rd(8'h6f);
    `CHK(d, 32'h1)
    repeat (40) @(posedge aclk);
    ext_val <= 16'h0000;
    repeat (150) @(posedge aclk);
    rd(8'h95);
    `CHK(d[9], 1'b0)
    rd(8'h6f);
    `CHK(d, 32'h0)
    ext_val <= 16'h0200;
    t0 = $time;
    repeat (45) @(posedge aclk);
    rd(8'h95);
    `CHK(d[9], 1'b0)
    pol(8'h95, 32'h200, 32'h200);
    `CHK(($time - t0) <= 4400, 1'b1)
    $display("test debounce done");
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ovr();
    t_deb();
    finish_test();
  end
endmodule // pod_top_tb
